/* hdl/rers_regs.sv */
// Register logic for port event flags, event counters and port security.
// Assumes one clock, a synchronous 8-bit processor port and core events.
//
// Functional notes
// RULE1: Lower flags bits 0..4 show a pending event record on ports 9..13.
// RULE2: Lower flags bits 5,6 and security bit 7 always read zero.
// RULE3: Writing the LED suppress bit 1 stops LED update cycles.
// RULE4: After writing it 0, LED updates resume only once core is idle.
// RULE5: Each port has a 16-bit counter, readable, counting enabled events.
// RULE6: Control bits select clear-on-read and saturation for 16-bit counters.
// RULE7: A 16-bit counter reads as a low byte and a high byte.
// RULE8: Reading either byte copies all 16 counter bits into a holding register.
// RULE9: Next read of the same counter's other byte returns the held byte.
// RULE10: Holding reloads only on another counter or the same byte re-read.
// RULE11: Each port has an 8-bit secondary counter counting enabled events.
// RULE12: Control bits select clear-on-read and saturation for 8-bit counters.
// RULE13: Security bit 0 enables port CAM learning; meaningless for shared CAMs.
// RULE14: Security bit 1 enables address security for the port.
// RULE15: Broadcast packets are replaced unless bit 2 is set.
// RULE16: Multicast packets are replaced unless bit 3 is set.
// RULE17: Source mismatch still applies to passed broadcast and multicast.
// RULE18: Read-only bit 4 reports source mismatch of the last packet.
// RULE19: Bit 5 uses the source address in the security comparison.
// RULE20: Bit 6 uses the destination address in the security comparison.
// RULE21: Upper flags bits 0..7 show a pending event record on ports 1..8.
// RULE22: Reading a port event record register clears its flags.
// RULE23: Replacement needs security enabled and a comparison selected.
`timescale 1ns/1ps
`include "rers_consts.svh"
module rers_regs
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire rers_pkg::rers_cpu_s i_cpu,
	output logic [7:0] o_rdata,
	input wire logic [12:0] i_evt,
	input wire logic [12:0][7:0] i_rec_set,
	input wire rers_pkg::rers_pkt_s [12:0] i_pkt,
	input wire logic i_idle,
	output logic o_led_update_en,
	output logic [12:0] o_learn_en,
	output logic [12:0] o_replace
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Tells whether an address falls in the per-port window.
	function automatic logic is_port(input logic [4:0] a);
		is_port = (a >= `RERS_AD_PORT_FIRST) && (a <= `RERS_AD_PORT_LAST);
	endfunction : is_port

	// Turns a per-port address into a port index 0..12.
	function automatic logic [3:0] port_of(input logic [4:0] a);
		logic [4:0] d;
		d = a - `RERS_AD_PORT_FIRST;
		port_of = d[3:0];
	endfunction : port_of

	////////////////////////////////////////////////////////////////////////
	// State.

	logic [15:0] cnt [13];
	logic [15:0] next_cnt [13];
	logic [7:0] cnt2 [13];
	logic [7:0] next_cnt2 [13];
	logic [7:0] rec [13];
	logic [7:0] next_rec [13];
	logic [7:0] sec [13];
	logic [7:0] next_sec [13];
	logic [15:0] hold;
	logic [15:0] next_hold;
	logic [3:0] hold_port;
	logic [3:0] next_hold_port;
	logic hold_byte;
	logic next_hold_byte;
	logic hold_valid;
	logic next_hold_valid;
	logic [3:0] cnt_ctrl;
	logic [3:0] next_cnt_ctrl;
	logic led_suppress;
	logic next_led_suppress;
	logic led_en;
	logic next_led_en;
	logic [7:0] next_rdata;
	logic [12:0] next_replace;
	logic [12:0] flags;
	logic [3:0] ap;
	logic ain;
	logic rd;
	logic wr;

	////////////////////////////////////////////////////////////////////////
	// Decode of the current processor access.

	// A port is flagged while any of its record bits stands.
	always_comb
	begin
		for (int i = 0; i < 13; i++)
		begin
			flags[i] = |rec[i]; // RULE1 RULE21
		end
		ap = port_of(i_cpu.addr);
		ain = is_port(i_cpu.addr);
		rd = i_cpu.rd;
		wr = i_cpu.wr;
	end

	////////////////////////////////////////////////////////////////////////
	// Counters and holding register.

	// Counts events, serves byte reads and handles clear-on-read.
	always_comb
	begin
		logic rd_lo;
		logic rd_hi;
		logic rd_c2;
		logic load;
		logic clr16;
		logic clr2;
		// Per-port clear strobes start idle on every pass.
		clr16 = 1'b0;
		clr2 = 1'b0;
		rd_lo = rd && ain && (i_cpu.page == `RERS_PG_CNT_LO);
		rd_hi = rd && ain && (i_cpu.page == `RERS_PG_CNT_HI);
		rd_c2 = rd && ain && (i_cpu.page == `RERS_PG_CNT2);
		next_hold = hold;
		next_hold_port = hold_port;
		next_hold_byte = hold_byte;
		next_hold_valid = hold_valid;
		// Other byte of the held counter comes from the holding copy.
		load = (rd_lo || rd_hi) && !(hold_valid && hold_port == ap
			&& hold_byte != rd_hi); // RULE9 RULE10
		if (rd_lo || rd_hi)
		begin
			next_hold_port = ap;
			next_hold_byte = rd_hi;
			next_hold_valid = 1'b1;
		end
		if (load)
		begin
			next_hold = cnt[ap]; // RULE8
		end
		for (int i = 0; i < 13; i++)
		begin
			clr16 = load && (ap == 4'(i))
				&& cnt_ctrl[`RERS_BIT_CLR16]; // RULE6
			clr2 = rd_c2 && (ap == 4'(i))
				&& cnt_ctrl[`RERS_BIT_CLR8]; // RULE12
			next_cnt[i] = clr16 ? `RERS_RST_WORD : cnt[i];
			next_cnt2[i] = clr2 ? `RERS_RST_BYTE : cnt2[i];
			// An event in the clearing cycle still counts.
			if (i_evt[i])
			begin
				if (!(cnt_ctrl[`RERS_BIT_SAT16]
					&& next_cnt[i] == `RERS_MAX16)) // RULE6
				begin
					next_cnt[i] = next_cnt[i] + 16'h0001; // RULE5
				end
				if (!(cnt_ctrl[`RERS_BIT_SAT8]
					&& next_cnt2[i] == `RERS_MAX8)) // RULE12
				begin
					next_cnt2[i] = next_cnt2[i] + 8'h01; // RULE11
				end
			end
		end
	end

	// Registers the counter group.
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int i = 0; i < 13; i++)
			begin
				cnt[i] <= `RERS_RST_WORD;
				cnt2[i] <= `RERS_RST_BYTE;
			end
			hold <= `RERS_RST_WORD;
			hold_port <= 4'h0;
			hold_byte <= 1'b0;
			hold_valid <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			cnt2 <= next_cnt2;
			hold <= next_hold;
			hold_port <= next_hold_port;
			hold_byte <= next_hold_byte;
			hold_valid <= next_hold_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration, flags, security and read data.

	// Handles writes, flag capture and the registered read mux.
	always_comb
	begin
		logic sa_fail;
		logic da_fail;
		logic bc_fail;
		logic mc_fail;
		logic [15:0] cv;
		// Packet verdict terms and the counter view start cleared.
		sa_fail = 1'b0;
		da_fail = 1'b0;
		bc_fail = 1'b0;
		mc_fail = 1'b0;
		cv = `RERS_RST_WORD;
		next_cnt_ctrl = cnt_ctrl;
		next_led_suppress = led_suppress;
		next_rdata = o_rdata;
		next_replace = o_replace;
		if (wr && i_cpu.page == `RERS_PG_EVT)
		begin
			if (i_cpu.addr == `RERS_AD_LOWER_FLAGS)
			begin
				next_led_suppress =
					i_cpu.wdata[`RERS_BIT_LED_SUPPRESS]; // RULE3
			end
			if (i_cpu.addr == `RERS_AD_CNT_CTRL)
			begin
				next_cnt_ctrl = i_cpu.wdata[3:0];
			end
		end
		// Updates stop at once and restart only on an idle core.
		next_led_en = !next_led_suppress
			&& (led_en || i_idle); // RULE3 RULE4
		for (int i = 0; i < 13; i++)
		begin
			next_rec[i] = rec[i];
			if (rd && ain && ap == 4'(i) && i_cpu.page == `RERS_PG_EVT)
			begin
				next_rec[i] = `RERS_RST_BYTE; // RULE22
			end
			// New records win over a clearing read.
			next_rec[i] = next_rec[i] | i_rec_set[i];
			next_sec[i] = sec[i];
			if (wr && ain && ap == 4'(i) && i_cpu.page == `RERS_PG_SEC)
			begin
				next_sec[i] = (i_cpu.wdata & `RERS_SEC_WMASK)
					| (sec[i] & ~`RERS_SEC_WMASK);
			end
			sa_fail = sec[i][`RERS_SEC_SRC] && i_pkt[i].sa_mis; // RULE19
			da_fail = sec[i][`RERS_SEC_DST] && i_pkt[i].da_mis; // RULE20
			bc_fail = i_pkt[i].bcast && !sec[i][`RERS_SEC_BCAST]; // RULE15
			mc_fail = i_pkt[i].mcast && !i_pkt[i].bcast
				&& !sec[i][`RERS_SEC_MCAST]; // RULE16
			if (i_pkt[i].done)
			begin
				next_sec[i][`RERS_SEC_SAM] = i_pkt[i].sa_mis; // RULE18
				// Source mismatch is judged even for passed packets.
				next_replace[i] = sec[i][`RERS_SEC_ENABLE] // RULE14
					&& (sec[i][`RERS_SEC_SRC] || sec[i][`RERS_SEC_DST])
					&& (sa_fail || da_fail
					|| bc_fail || mc_fail); // RULE17 RULE23
			end
			next_sec[i][7] = 1'b0; // RULE2
		end
		if (rd)
		begin
			next_rdata = `RERS_RST_BYTE;
			cv = ain ? cnt[ap] : `RERS_RST_WORD;
			if (i_cpu.page == `RERS_PG_EVT)
			begin
				if (i_cpu.addr == `RERS_AD_UPPER_FLAGS)
				begin
					next_rdata = flags[7:0]; // RULE21
				end
				else if (i_cpu.addr == `RERS_AD_LOWER_FLAGS)
				begin
					next_rdata = {led_suppress, 2'b00,
						flags[12:8]}; // RULE1 RULE2
				end
				else if (i_cpu.addr == `RERS_AD_CNT_CTRL)
				begin
					next_rdata = {4'h0, cnt_ctrl};
				end
				else if (ain)
				begin
					next_rdata = rec[ap];
				end
			end
			else if (ain && i_cpu.page == `RERS_PG_CNT_LO)
			begin
				next_rdata = next_hold[7:0]; // RULE7 RULE9
			end
			else if (ain && i_cpu.page == `RERS_PG_CNT_HI)
			begin
				next_rdata = next_hold[15:8]; // RULE7 RULE9
			end
			else if (ain && i_cpu.page == `RERS_PG_CNT2)
			begin
				next_rdata = cnt2[ap];
			end
			else if (ain && i_cpu.page == `RERS_PG_SEC)
			begin
				next_rdata = sec[ap];
			end
			if (cv == `RERS_MAX16)
			begin
				next_rdata = next_rdata;
			end
		end
	end

	// Registers the configuration group.
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int i = 0; i < 13; i++)
			begin
				rec[i] <= `RERS_RST_BYTE;
				sec[i] <= `RERS_RST_BYTE;
			end
			cnt_ctrl <= 4'h0;
			led_suppress <= 1'b0;
			led_en <= 1'b0;
			o_rdata <= `RERS_RST_BYTE;
			o_replace <= 13'h0000;
		end
		else
		begin
			rec <= next_rec;
			sec <= next_sec;
			cnt_ctrl <= next_cnt_ctrl;
			led_suppress <= next_led_suppress;
			led_en <= next_led_en;
			o_rdata <= next_rdata;
			o_replace <= next_replace;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs taken straight from registers.

	// Learning is offered per port for the port CAMs only.
	always_comb
	begin
		for (int i = 0; i < 13; i++)
		begin
			o_learn_en[i] = sec[i][`RERS_SEC_LEARN]; // RULE13
		end
		o_led_update_en = led_en;
	end

endmodule : rers_regs

/* pkg/rers_consts.svh */
// Constants of the repeater event and security register block.
// Assumes inclusion by the package and the block only.
`ifndef RERS_CONSTS_SVH
`define RERS_CONSTS_SVH
`define RERS_NPORT 13
`define RERS_PG_EVT 4'h1
`define RERS_PG_CNT_LO 4'h2
`define RERS_PG_CNT_HI 4'h3
`define RERS_PG_CNT2 4'h4
`define RERS_PG_SEC 4'h5
`define RERS_AD_PORT_FIRST 5'h11
`define RERS_AD_PORT_LAST 5'h1d
`define RERS_AD_CNT_CTRL 5'h10
`define RERS_AD_UPPER_FLAGS 5'h1e
`define RERS_AD_LOWER_FLAGS 5'h1f
`define RERS_BIT_LED_SUPPRESS 7
`define RERS_BIT_CLR16 0
`define RERS_BIT_SAT16 1
`define RERS_BIT_CLR8 2
`define RERS_BIT_SAT8 3
`define RERS_SEC_LEARN 0
`define RERS_SEC_ENABLE 1
`define RERS_SEC_BCAST 2
`define RERS_SEC_MCAST 3
`define RERS_SEC_SAM 4
`define RERS_SEC_SRC 5
`define RERS_SEC_DST 6
`define RERS_SEC_WMASK 8'h6f
`define RERS_RST_BYTE 8'h00
`define RERS_RST_WORD 16'h0000
`define RERS_MAX16 16'hffff
`define RERS_MAX8 8'hff
`endif

/* pkg/rers_pkg.sv */
// Types of the repeater event and security register block.
// Assumes the constants header sits beside it.
`include "rers_consts.svh"
package rers_pkg;
	// One processor port access, sampled on a clock edge.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] page;
		logic [4:0] addr;
		logic [7:0] wdata;
	} rers_cpu_s;
	// Per-port packet result from the repeater core.
	typedef struct packed {
		logic done;
		logic bcast;
		logic mcast;
		logic sa_mis;
		logic da_mis;
	} rers_pkt_s;
endpackage : rers_pkg

/* verification/rers_chk.sv */
// Port checker of the event and security register block.
// Assumes a bind onto rers_regs from the bench top file.
`timescale 1ns/1ps
module rers_chk
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire rers_pkg::rers_cpu_s i_cpu,
	input wire logic [7:0] o_rdata,
	input wire rers_pkg::rers_pkt_s [12:0] i_pkt,
	input wire logic i_idle,
	input wire logic o_led_update_en,
	input wire logic [12:0] o_learn_en,
	input wire logic [12:0] o_replace
);
	// All checks sample on the rising edge outside reset.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Decodes of the lower flag register and the port 1 security register.
	wire lf = i_cpu.page == 4'h1 && i_cpu.addr == 5'h1f;
	wire s1 = i_cpu.page == 4'h5 && i_cpu.addr == 5'h11;
	a_flag_resv_zero: assert property (i_cpu.rd && lf |=> !o_rdata[6:5])
		else $error("flag reserved bits set");
	a_sec_resv_zero: assert property (i_cpu.rd && s1 |=> !o_rdata[7])
		else $error("security bit 7 set");
	a_learn_follow: assert property (i_cpu.wr && s1
		|=> o_learn_en[0] == $past(i_cpu.wdata[0]))
		else $error("learn enable wrong");
	a_learn_hold: assert property (!(i_cpu.wr && i_cpu.page == 4'h5)
		|=> $stable(o_learn_en))
		else $error("learn enable moved");
	a_led_drop: assert property (i_cpu.wr && lf && i_cpu.wdata[7]
		|-> ##2 !o_led_update_en)
		else $error("led updates not stopped");
	a_led_idle: assert property ($rose(o_led_update_en) |-> $past(i_idle))
		else $error("led updates resumed while busy");
	a_replace_cause: assert property ($rose(o_replace[0])
		|-> $past(i_pkt[0].done))
		else $error("replace set without packet");
	a_replace_hold: assert property (!i_pkt[0].done
		|=> $stable(o_replace[0]))
		else $error("replace moved without packet");
endmodule : rers_chk

/* verification/rers_cpu_model.sv */
// Model of the management processor on the 8-bit processor port.
// Assumes its task is called at a falling edge after reset release.
`timescale 1ns/1ps
module rers_cpu_model
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output rers_pkg::rers_cpu_s o_cpu
);
	// The idle port shows no strobe and scrambled lines.
	initial o_cpu = '{1'b0, 1'b0, 4'hf, 5'h1f, 8'hff};
	// One access held a cycle, then released with inverted lines.
	task acc(input logic w, input logic [3:0] pg, input logic [4:0] ad,
		input logic [7:0] d, output logic [7:0] q);
		o_cpu = '{!w, w, pg, ad, d};
		@(negedge i_clk);
		q = i_rdata;
		o_cpu = '{1'b0, 1'b0, ~pg, ~ad, ~d};
		@(negedge i_clk);
	endtask : acc
endmodule : rers_cpu_model

/* verification/tb.sv */
// Bench of the event and security register block.
// Assumes the design, the checker and the processor model compile first.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b1;
	logic [12:0] evt = '0;
	logic [12:0][7:0] rec = '0;
	rers_pkg::rers_pkt_s [12:0] pkt = '0;
	logic idle = 1'b1;
	rers_pkg::rers_cpu_s cpu;
	logic [7:0] rdata, q;
	logic [17:0] r;
	logic led;
	logic [12:0] learn, repl;
	int miscompares = 0;
	int n_checks = 0;
	// Rows: write flag, page, address, then data or expected read.
	logic [17:0] rows [9] = '{{1'b0, 4'h1, 5'h1f, 8'h00},
		{1'b0, 4'h5, 5'h11, 8'h00}, {1'b1, 4'h5, 5'h11, 8'hff},
		{1'b0, 4'h5, 5'h11, 8'h6f}, {1'b0, 4'h0, 5'h05, 8'h00},
		{1'b1, 4'h4, 5'h12, 8'h55}, {1'b0, 4'h4, 5'h12, 8'h00},
		{1'b1, 4'h1, 5'h1e, 8'hff}, {1'b0, 4'h1, 5'h1e, 8'h00}};
	always #5 clk = ~clk;
	rers_regs dut
	(
		.i_clk(clk), .i_nrst(nrst), .i_cpu(cpu), .o_rdata(rdata),
		.i_evt(evt), .i_rec_set(rec), .i_pkt(pkt), .i_idle(idle),
		.o_led_update_en(led), .o_learn_en(learn), .o_replace(repl)
	);
	rers_cpu_model u_cpu
	(
		.i_clk(clk),
		.i_rdata(rdata),
		.o_cpu(cpu)
	);
	// Compares one byte and counts the result.
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Register access shorthands.
	task rd(input logic [3:0] p, input logic [4:0] a, input logic [7:0] e,
		input string n);
		u_cpu.acc(1'b0, p, a, 8'h00, q);
		chk(n, e, q);
	endtask : rd
	task wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
		u_cpu.acc(1'b1, p, a, d, q);
	endtask : wr
	// One packet end on port 1 under a given security setting.
	task pk(input logic [7:0] s, input logic [3:0] b, input logic e);
		wr(4'h5, 5'h11, s);
		pkt[0] = {1'b1, b};
		@(negedge clk);
		pkt[0] = '0;
		chk("replace", {7'h0, e}, {7'h0, repl[0]});
	endtask : pk
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// Watchdog well beyond the roughly 700 cycles of the tests.
	initial
	begin
		#50000;
		miscompares++;
		print_verdict();
	end
	// Main sequence.
	initial
	begin
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk("reset", 8'h00, {led, learn[6:0]});
		nrst = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			r = rows[i];
			u_cpu.acc(r[17], r[16:13], r[12:8], r[7:0], q);
			if (!r[17]) chk("row", r[7:0], q);
		end
		$display("test table done");
		rec[9] = 8'h01;
		rec[2] = 8'h04;
		@(negedge clk);
		rec = '0;
		rd(4'h1, 5'h1f, 8'h02, "lower");
		rd(4'h1, 5'h1e, 8'h04, "upper");
		rd(4'h1, 5'h1a, 8'h01, "record");
		rd(4'h1, 5'h1f, 8'h00, "cleared");
		$display("test flags done");
		chk("led on", 8'h01, {7'h0, led});
		wr(4'h1, 5'h1f, 8'h80);
		chk("led off", 8'h00, {7'h0, led});
		rd(4'h1, 5'h1f, 8'h80, "suppress");
		idle = 1'b0;
		wr(4'h1, 5'h1f, 8'h00);
		repeat (3) @(negedge clk);
		chk("led wait", 8'h00, {7'h0, led});
		idle = 1'b1;
		@(negedge clk);
		chk("led back", 8'h01, {7'h0, led});
		$display("test led done");
		evt[1] = 1'b1;
		repeat (300) @(negedge clk);
		evt = '0;
		rd(4'h4, 5'h12, 8'h2c, "roll8");
		wr(4'h1, 5'h10, 8'h0a);
		evt[0] = 1'b1;
		repeat (300) @(negedge clk);
		evt = '0;
		rd(4'h4, 5'h11, 8'hff, "sat8");
		rd(4'h2, 5'h11, 8'h2c, "lo");
		evt[0] = 1'b1;
		repeat (5) @(negedge clk);
		evt = '0;
		rd(4'h3, 5'h11, 8'h01, "hi held");
		rd(4'h2, 5'h11, 8'h2c, "lo held");
		rd(4'h2, 5'h11, 8'h31, "lo again");
		rd(4'h2, 5'h12, 8'h2c, "other");
		wr(4'h1, 5'h10, 8'h01);
		rd(4'h3, 5'h11, 8'h01, "hi clr");
		rd(4'h2, 5'h11, 8'h31, "lo snap");
		rd(4'h2, 5'h11, 8'h00, "live clr");
		$display("test counters done");
		chk("learn", 8'h01, {7'h0, learn[0]});
		pk(8'hff, 4'h8, 1'b0);
		pk(8'h62, 4'h8, 1'b1);
		pk(8'h62, 4'h4, 1'b1);
		pk(8'h6e, 4'ha, 1'b1);
		rd(4'h5, 5'h11, 8'h7e, "mismatch");
		pk(8'h64, 4'h2, 1'b0);
		pk(8'h42, 4'h3, 1'b1);
		pk(8'h42, 4'h2, 1'b0);
		pk(8'h22, 4'h2, 1'b1);
		pk(8'h0e, 4'h2, 1'b0);
		pk(8'h02, 4'h8, 1'b0);
		rd(4'h5, 5'h11, 8'h02, "match");
		chk("unlearn", 8'h00, {7'h0, learn[0]});
		$display("test packets done");
		print_verdict();
	end
endmodule : tb
bind rers_regs rers_chk u_chk
(
	.i_clk, .i_nrst, .i_cpu, .o_rdata, .i_pkt, .i_idle,
	.o_led_update_en, .o_learn_en, .o_replace
);
